// ---- logic/power_mode_control.sv ----
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// [RULE1] both detect bits set keep regulator on through every stop mode
// [RULE2] deep stop request with detect-in-stop enabled becomes light stop
// [RULE3] no deep stop from low power run; lpr and ppd select exclude each other; one write setting both from clear sets both
// [RULE4] stop instruction in low power run goes to light stop
// [RULE5] reset ending light stop returns to normal run
// [RULE6] wake_full clear: interrupt in light stop from low_power_run returns to low_power_run
// [RULE7] wake_full set: interrupt returns to run and clears lpr and status
// [RULE8] run when not debug and no lpr, both detect bits, or debug allowed
// [RULE9] low_power_run when lpr set, no ppd, no debug, a detect bit clear
// [RULE10] wait stops cpu clock, peripherals run, regulator on
// [RULE11] low power wait: cpu off, slow peripherals, standby, debug clock off
// [RULE12] light stop standby unless both detect bits or debug; debug clock on debug
// [RULE13] deep stop only with no debug, no lpr, ppd select, a detect bit clear
// [RULE14] deep stop powers down all but the real time counter
// [RULE15] debug_mode_allow written only by the background debug port
// [RULE16] deep stop left by wake pin low; others by interrupt
// [RULE17] software sets low_power_run_request last when entering low_power_run
// [RULE18] software reloads its environment from ram after deep stop
// [RULE19] light stop exits to run on reset, or interrupt without lpr or with wake_full
// [RULE20] wake pin low in deep stop starts a full power-on reset
// [RULE21] stop with stop_instruction_allow clear forces illegal opcode reset
// [RULE22] deep stop wake sets powerdown flag and holds pin latch until ack
// [RULE23] mode-select bits sampled when stop or wait executes
module power_mode_control
   import power_mode_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [3:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   input wire logic debug_wr_in,
   input wire logic debug_mode_allow_in,
   input wire logic stop_exec_in,
   input wire logic wait_exec_in,
   input wire logic irq_in,
   input wire logic wake_pin_in,
   output logic illegal_op_reset_out,
   output logic por_request_out,
   output power_ctrl_t power_out,
   output mode_t mode_out
);

   // ---------------------------------------------------------------
   // software registers
   // ---------------------------------------------------------------
   logic lvd_on_r;
   logic lvd_stop_r;
   logic lpr_r;
   logic low_power_run_status_r;
   logic wake_full_r;
   logic ppd_sel_r;
   logic stop_allow_r;
   logic debug_allow_r;
   logic powerdown_wake_flag_r;
   logic pins_latched_r;
   mode_t mode_r;
   mode_t mode_nxt;
   mode_t lstop_origin_r;
   mode_sel_t sel_r;
   logic illegal_r;
   logic por_r;
   power_ctrl_t power_r;
   power_ctrl_t power_nxt;
   logic ctrl_wr;
   logic irq_wake_full;
   logic ack_wr;

   assign ctrl_wr = wr_in && (addr_in == ADDR_CTRL);
   assign ack_wr = ctrl_wr && wdata_in[CTRL_PPD_ACK];

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         lvd_on_r <= CTRL_RESET[CTRL_LVD_ON];
         lvd_stop_r <= CTRL_RESET[CTRL_LVD_STOP];
         wake_full_r <= CTRL_RESET[CTRL_WAKE_FULL];
         stop_allow_r <= CTRL_RESET[CTRL_STOP_ALLOW];
      end
      else if (ctrl_wr)
      begin
         lvd_on_r <= wdata_in[CTRL_LVD_ON];
         lvd_stop_r <= wdata_in[CTRL_LVD_STOP];
         wake_full_r <= wdata_in[CTRL_WAKE_FULL];
         stop_allow_r <= wdata_in[CTRL_STOP_ALLOW];
      end
   end

   // a write setting lpr or ppd select is dropped while the other is already set; wake to full regulation clears lpr
   assign irq_wake_full = irq_in && wake_full_r &&
      ((mode_r == MODE_LSTOP) || (mode_r == MODE_LOW_POWER_WAIT) || (mode_r == MODE_LOW_POWER_RUN));

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         lpr_r <= CTRL_RESET[CTRL_LPR];
         ppd_sel_r <= CTRL_RESET[CTRL_PPD_SEL];
      end
      else
      begin
         if (irq_wake_full)
            lpr_r <= 1'b0; // RULE7
         else if (ctrl_wr && !(wdata_in[CTRL_LPR] && ppd_sel_r))
            lpr_r <= wdata_in[CTRL_LPR]; // RULE3
         if (ctrl_wr && !(wdata_in[CTRL_PPD_SEL] && lpr_r))
            ppd_sel_r <= wdata_in[CTRL_PPD_SEL]; // RULE3
      end
   end

   // only the background debug port reaches this bit
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         debug_allow_r <= 1'b0;
      else if (debug_wr_in)
         debug_allow_r <= debug_mode_allow_in; // RULE15
   end

   // ---------------------------------------------------------------
   // instruction-time sampling
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         sel_r <= '0;
      else if (stop_exec_in || wait_exec_in)
         sel_r <= '{debug_allow_r, lvd_on_r, lvd_stop_r, lpr_r, ppd_sel_r,
                    wake_full_r}; // RULE23
   end

   // ---------------------------------------------------------------
   // mode sequencing
   // ---------------------------------------------------------------
   logic lp_ok;
   logic both_lvd;
   assign both_lvd = lvd_on_r && lvd_stop_r;
   assign lp_ok = !debug_allow_r && lpr_r && !ppd_sel_r && !both_lvd; // RULE9

   always_comb
   begin
      mode_nxt = mode_r;
      case (mode_r)
         MODE_RUN:
         begin
            if (stop_exec_in && stop_allow_r)
            begin
               if (!debug_allow_r && !lpr_r && ppd_sel_r && !both_lvd)
                  mode_nxt = MODE_DSTOP; // RULE13
               else
                  mode_nxt = MODE_LSTOP; // RULE2
            end
            else if (wait_exec_in)
               mode_nxt = MODE_WAIT;
            else if (lp_ok)
               mode_nxt = MODE_LOW_POWER_RUN; // RULE8
         end
         MODE_LOW_POWER_RUN:
         begin
            if (stop_exec_in && stop_allow_r)
               mode_nxt = MODE_LSTOP; // RULE4
            else if (wait_exec_in)
               mode_nxt = MODE_LOW_POWER_WAIT;
            else if (!lp_ok)
               mode_nxt = MODE_RUN; // RULE8
         end
         MODE_WAIT:
         begin
            if (irq_in)
               mode_nxt = MODE_RUN; // RULE16
         end
         MODE_LOW_POWER_WAIT:
         begin
            if (irq_in)
               mode_nxt = sel_r.wake_full ? MODE_RUN : MODE_LOW_POWER_RUN; // RULE16
         end
         MODE_LSTOP:
         begin
            if (irq_in)
            begin
               if ((lstop_origin_r == MODE_LOW_POWER_RUN) && !sel_r.wake_full)
                  mode_nxt = MODE_LOW_POWER_RUN; // RULE6
               else
                  mode_nxt = MODE_RUN; // RULE19
            end
         end
         MODE_DSTOP:
         begin
            if (!wake_pin_in)
               mode_nxt = MODE_POR; // RULE20
         end
         MODE_POR:
            mode_nxt = MODE_RUN;
         default:
            mode_nxt = MODE_RUN;
      endcase
   end

   // reset always returns to normal run
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         mode_r <= MODE_RUN; // RULE5
      else
         mode_r <= mode_nxt;
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         lstop_origin_r <= MODE_RUN;
      else if (mode_nxt == MODE_LSTOP && mode_r != MODE_LSTOP)
         lstop_origin_r <= mode_r;
   end

   // low power run status follows the mode
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         low_power_run_status_r <= 1'b0;
      else
         low_power_run_status_r <= (mode_nxt == MODE_LOW_POWER_RUN) || (mode_nxt == MODE_LOW_POWER_WAIT); // RULE7
   end

   // illegal stop forces a reset request
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         illegal_r <= 1'b0;
      else
         illegal_r <= stop_exec_in && !stop_allow_r &&
            ((mode_r == MODE_RUN) || (mode_r == MODE_LOW_POWER_RUN)); // RULE21
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         por_r <= 1'b0;
      else
         por_r <= (mode_r == MODE_DSTOP) && !wake_pin_in; // RULE20
   end

   // powerdown flag and pin latch, set wins over ack
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         powerdown_wake_flag_r <= 1'b0;
         pins_latched_r <= 1'b0;
      end
      else if (mode_nxt == MODE_DSTOP || mode_r == MODE_POR)
      begin
         powerdown_wake_flag_r <= (mode_r == MODE_POR); // RULE22
         pins_latched_r <= 1'b1; // RULE22
      end
      else if (ack_wr)
      begin
         powerdown_wake_flag_r <= 1'b0; // RULE22
         pins_latched_r <= 1'b0; // RULE22
      end
   end

   // ---------------------------------------------------------------
   // gating and regulator outputs
   // ---------------------------------------------------------------
   always_comb
   begin
      power_nxt = '0;
      power_nxt.regulator = REG_ON;
      power_nxt.core_powered = 1'b1;
      power_nxt.rtc_powered = 1'b1;
      power_nxt.pins_latched = pins_latched_r;
      power_nxt.debug_clk_on = debug_allow_r;
      case (mode_nxt)
         MODE_RUN:
         begin
            power_nxt.cpu_clk_on = 1'b1; // RULE8
            power_nxt.periph_clk_on = 1'b1;
         end
         MODE_WAIT:
         begin
            power_nxt.periph_clk_on = 1'b1; // RULE10
         end
         MODE_LOW_POWER_RUN:
         begin
            power_nxt.cpu_clk_on = 1'b1;
            power_nxt.periph_clk_on = 1'b1;
            power_nxt.periph_low_speed = 1'b1;
            power_nxt.clk_module_bypass_lp = 1'b1; // RULE9
            power_nxt.regulator = REG_STANDBY; // RULE9
            power_nxt.debug_clk_on = 1'b0;
         end
         MODE_LOW_POWER_WAIT:
         begin
            power_nxt.periph_clk_on = 1'b1;
            power_nxt.periph_low_speed = 1'b1;
            power_nxt.clk_module_bypass_lp = 1'b1; // RULE11
            power_nxt.regulator = REG_STANDBY; // RULE11
            power_nxt.debug_clk_on = 1'b0; // RULE11
         end
         MODE_LSTOP:
         begin
            if (!(lvd_on_r && lvd_stop_r) && !debug_allow_r)
               power_nxt.regulator = REG_STANDBY; // RULE12
            else
               power_nxt.regulator = REG_ON; // RULE1
         end
         MODE_DSTOP:
         begin
            power_nxt.regulator = REG_PARTIAL_DOWN; // RULE13
            power_nxt.core_powered = 1'b0; // RULE14
            power_nxt.debug_clk_on = 1'b0;
            power_nxt.pins_latched = 1'b1;
         end
         MODE_POR:
         begin
            power_nxt.core_powered = 1'b0;
            power_nxt.debug_clk_on = 1'b0;
            power_nxt.pins_latched = 1'b1;
         end
         default:
         begin
            power_nxt.cpu_clk_on = 1'b1;
            power_nxt.periph_clk_on = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         power_r <= '0;
         power_r.core_powered <= 1'b1;
         power_r.rtc_powered <= 1'b1;
         power_r.cpu_clk_on <= 1'b1;
         power_r.periph_clk_on <= 1'b1;
      end
      else
         power_r <= power_nxt;
   end

   // ---------------------------------------------------------------
   // register read port
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         rdata_out <= READ_ZERO;
      else if (rd_in)
      begin
         rdata_out <= READ_ZERO;
         case (addr_in)
            ADDR_CTRL:
            begin
               rdata_out[CTRL_LVD_ON] <= lvd_on_r;
               rdata_out[CTRL_LVD_STOP] <= lvd_stop_r;
               rdata_out[CTRL_LPR] <= lpr_r;
               rdata_out[CTRL_WAKE_FULL] <= wake_full_r;
               rdata_out[CTRL_PPD_SEL] <= ppd_sel_r;
               rdata_out[CTRL_STOP_ALLOW] <= stop_allow_r;
            end
            ADDR_STATUS:
            begin
               rdata_out[STAT_LOW_POWER_RUN_STATUS] <= low_power_run_status_r;
               rdata_out[STAT_POWERDOWN_WAKE_FLAG] <= powerdown_wake_flag_r;
               rdata_out[STAT_MODE_LO +: 3] <= mode_r;
            end
            ADDR_DEBUG:
               rdata_out[0] <= debug_allow_r;
            default:
               rdata_out <= READ_ZERO;
         endcase
      end
   end

   assign illegal_op_reset_out = illegal_r;
   assign por_request_out = por_r;
   assign power_out = power_r;
   assign mode_out = mode_r;

endmodule

`default_nettype wire

// ---- logic/power_mode_pkg.sv ----
package power_mode_pkg;

   // ---------------------------------------------------------------
   // register map (plain port, word index)
   // ---------------------------------------------------------------
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h1;
   localparam logic [3:0] ADDR_DEBUG = 4'h2;

   // control register bit positions
   localparam int CTRL_LVD_ON = 0;
   localparam int CTRL_LVD_STOP = 1;
   localparam int CTRL_LPR = 2;
   localparam int CTRL_WAKE_FULL = 3;
   localparam int CTRL_PPD_SEL = 4;
   localparam int CTRL_STOP_ALLOW = 5;
   localparam int CTRL_PPD_ACK = 6;

   // status register bit positions
   localparam int STAT_LOW_POWER_RUN_STATUS = 0;
   localparam int STAT_POWERDOWN_WAKE_FLAG = 1;
   localparam int STAT_MODE_LO = 4;

   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // ---------------------------------------------------------------
   // modes, one bit apart along run <-> wait, low power run <-> low power wait and deep stop -> por
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_RUN = 3'h0,
      MODE_WAIT = 3'h1,
      MODE_LOW_POWER_RUN = 3'h3,
      MODE_LOW_POWER_WAIT = 3'h2,
      MODE_LSTOP = 3'h6,
      MODE_DSTOP = 3'h7,
      MODE_POR = 3'h5
   } mode_t;

   typedef enum logic [1:0] {
      REG_ON = 2'h0,
      REG_STANDBY = 2'h1,
      REG_PARTIAL_DOWN = 2'h2
   } regulator_t;

   // gating outputs grouped
   typedef struct packed {
      regulator_t regulator;
      logic cpu_clk_on;
      logic periph_clk_on;
      logic periph_low_speed;
      logic debug_clk_on;
      logic clk_module_bypass_lp;
      logic core_powered;
      logic rtc_powered;
      logic pins_latched;
   } power_ctrl_t;

   // mode-select bits sampled at instruction time
   typedef struct packed {
      logic debug_allow;
      logic lvd_on;
      logic lvd_stop;
      logic low_power_run_request;
      logic ppd_sel;
      logic wake_full;
   } mode_sel_t;

endpackage

// ---- verif/power_mode_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
// -------------------------------------------------
// mode and power output checks
// -------------------------------------------------
module power_mode_asserts
   import power_mode_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic stop_exec_in,
   input wire logic wait_exec_in,
   input wire logic irq_in,
   input wire logic wake_pin_in,
   input wire logic illegal_op_reset_out,
   input wire logic por_request_out,
   input wire power_ctrl_t power_out,
   input wire mode_t mode_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   sequence wake_seq;
      (mode_out == MODE_POR && por_request_out) ##1
         (mode_out == MODE_RUN && power_out.pins_latched);
   endsequence

   dstop_wake_a: assert property (mode_out == MODE_DSTOP && !wake_pin_in |=> wake_seq)
      else $error("deep stop wake sequence wrong");
   dstop_hold_a: assert property (mode_out == MODE_DSTOP && wake_pin_in |=> mode_out == MODE_DSTOP)
      else $error("deep stop left without wake pin");
   dstop_power_a: assert property (mode_out == MODE_DSTOP |-> power_out.regulator == REG_PARTIAL_DOWN
      && !power_out.core_powered && power_out.rtc_powered && power_out.pins_latched)
      else $error("deep stop power state wrong");
   low_power_run_stop_a: assert property (mode_out == MODE_LOW_POWER_RUN && stop_exec_in |=> mode_out != MODE_DSTOP)
      else $error("deep stop entered from low power run");
   lstop_wake_a: assert property (mode_out == MODE_LSTOP && irq_in |=> mode_out inside {MODE_RUN, MODE_LOW_POWER_RUN})
      else $error("light stop not left on interrupt");
   lstop_debug_a: assert property (mode_out == MODE_LSTOP && power_out.debug_clk_on |-> power_out.regulator == REG_ON)
      else $error("light stop debug regulator wrong");
   wait_power_a: assert property (mode_out == MODE_WAIT |-> !power_out.cpu_clk_on && power_out.periph_clk_on
      && power_out.regulator == REG_ON)
      else $error("wait power state wrong");
   low_power_wait_power_a: assert property (mode_out == MODE_LOW_POWER_WAIT |-> !power_out.cpu_clk_on && power_out.periph_low_speed
      && power_out.regulator == REG_STANDBY && !power_out.debug_clk_on)
      else $error("low power wait state wrong");
   wait_wake_a: assert property (mode_out == MODE_WAIT && irq_in |=> mode_out == MODE_RUN)
      else $error("wait not left on interrupt");
   wait_entry_a: assert property (mode_out == MODE_RUN && wait_exec_in && !stop_exec_in
      |=> mode_out == MODE_WAIT)
      else $error("wait instruction not taken");
   illegal_nostop_a: assert property (illegal_op_reset_out |-> !(mode_out inside {MODE_LSTOP, MODE_DSTOP}))
      else $error("stop entered with stop disallowed");
endmodule

bind power_mode_control power_mode_asserts u_chk (.clk_in, .rst_in, .stop_exec_in, .wait_exec_in,
   .irq_in, .wake_pin_in, .illegal_op_reset_out, .por_request_out, .power_out, .mode_out);
`default_nettype wire

// ---- verif/core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// -------------------------------------------------
// processor core and wake pin driver
// -------------------------------------------------
module core_model
   import power_mode_pkg::*;
(
   input wire logic clk_in,
   input wire mode_t mode_in,
   output logic stop_exec_out,
   output logic wait_exec_out,
   output logic irq_out,
   output logic wake_pin_out
);
   initial
   begin
      stop_exec_out = 1'b0;
      wait_exec_out = 1'b0;
      irq_out = 1'b0;
      wake_pin_out = 1'b1;
   end
   task exec_stop;
      stop_exec_out <= 1'b1;
      @(posedge clk_in);
      stop_exec_out <= 1'b0;
   endtask
   task exec_wait;
      wait_exec_out <= 1'b1;
      @(posedge clk_in);
      wait_exec_out <= 1'b0;
   endtask
   // pending interrupt held until the core runs again, for at most 8 cycles
   task interrupt;
      irq_out <= 1'b1;
      repeat (8)
      begin
         @(posedge clk_in);
         if (mode_in inside {MODE_RUN, MODE_LOW_POWER_RUN})
            break;
      end
      irq_out <= 1'b0;
   endtask
   // wake pin pulled up, driven low for one cycle
   task wake;
      wake_pin_out <= 1'b0;
      @(posedge clk_in);
      wake_pin_out <= 1'b1;
   endtask
endmodule
`default_nettype wire

// ---- verif/power_mode_control_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module power_mode_control_tb_top
   import power_mode_pkg::*;
;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [3:0] addr_in = 4'h0;
   logic [7:0] wdata_in = 8'h00;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic debug_wr_in = 1'b0;
   logic debug_mode_allow_in = 1'b0;
   logic stop_exec_in, wait_exec_in, irq_in, wake_pin_in;
   logic [7:0] rdata_out;
   logic illegal_op_reset_out;
   logic por_request_out;
   power_ctrl_t power_out;
   mode_t mode_out;
   int err_count = 0;
   int samples_checked = 0;
   int cycles = 0;

   initial
   begin
      forever #10 clk_in = ~clk_in;
   end

   power_mode_control u_dut (.clk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
      .debug_wr_in, .debug_mode_allow_in, .stop_exec_in, .wait_exec_in, .irq_in, .wake_pin_in,
      .illegal_op_reset_out, .por_request_out, .power_out, .mode_out);
   core_model u_core (.clk_in, .mode_in(mode_out), .stop_exec_out(stop_exec_in),
      .wait_exec_out(wait_exec_in), .irq_out(irq_in), .wake_pin_out(wake_pin_in));

   // -------------------------------------------------
   // helpers
   // -------------------------------------------------
   task wrap_up;
      if (err_count == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task chk1(input logic s, input logic e);
      chk({7'h00, s}, {7'h00, e});
   endtask
   task step(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   task wr2(input logic [3:0] a, input logic [7:0] d0, input logic [7:0] d1);
      addr_in <= a;
      wdata_in <= d0;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wdata_in <= d1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   task rd(input logic [3:0] a, input logic [7:0] exp);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      @(posedge clk_in);
      chk(rdata_out, exp);
   endtask
   task mode_is(input mode_t m, input regulator_t r);
      chk({5'h00, mode_out}, {5'h00, m});
      chk({6'h00, power_out.regulator}, {6'h00, r});
   endtask
   task dbg(input logic v);
      debug_mode_allow_in <= v;
      debug_wr_in <= 1'b1;
      @(posedge clk_in);
      debug_wr_in <= 1'b0;
   endtask
   task do_stop;
      u_core.exec_stop();
      step(1);
   endtask

   // -------------------------------------------------
   // scenarios
   // -------------------------------------------------
   task t_reset;
      mode_is(MODE_RUN, REG_ON);
      rd(ADDR_CTRL, CTRL_RESET);
      rd(4'hF, READ_ZERO);
      u_core.exec_stop();
      step(1);
      chk1(illegal_op_reset_out, 1'b1);
      mode_is(MODE_RUN, REG_ON);
   endtask
   task t_debug;
      wr(ADDR_DEBUG, 8'h01);
      rd(ADDR_DEBUG, 8'h00);
      dbg(1'b1);
      rd(ADDR_DEBUG, 8'h01);
      wr(ADDR_CTRL, 8'h30);
      do_stop();
      mode_is(MODE_LSTOP, REG_ON);
      chk1(power_out.debug_clk_on, 1'b1);
      u_core.interrupt();
      mode_is(MODE_RUN, REG_ON);
      dbg(1'b0);
      wr(ADDR_CTRL, 8'h33);
      do_stop();
      mode_is(MODE_LSTOP, REG_ON);
      chk1(power_out.debug_clk_on, 1'b0);
      u_core.interrupt();
      mode_is(MODE_RUN, REG_ON);
   endtask
   task t_deep;
      wr2(ADDR_CTRL, 8'h30, 8'h34);
      rd(ADDR_CTRL, 8'h30);
      fork
         wr(ADDR_CTRL, 8'h33);
         u_core.exec_stop();
      join
      step(1);
      mode_is(MODE_DSTOP, REG_PARTIAL_DOWN);
      chk1(power_out.core_powered, 1'b0);
      chk1(power_out.rtc_powered, 1'b1);
      u_core.interrupt();
      mode_is(MODE_DSTOP, REG_PARTIAL_DOWN);
      u_core.wake();
      step(1);
      chk1(por_request_out, 1'b1);
      step(1);
      mode_is(MODE_RUN, REG_ON);
      rd(ADDR_STATUS, 8'h02);
      chk1(power_out.pins_latched, 1'b1);
      wr(ADDR_CTRL, 8'h73);
      step(2);
      chk1(power_out.pins_latched, 1'b0);
      rd(ADDR_STATUS, 8'h00);
   endtask
   task t_low_power_run;
      wr2(ADDR_CTRL, 8'h20, 8'h24);
      step(2);
      mode_is(MODE_LOW_POWER_RUN, REG_STANDBY);
      chk1(power_out.clk_module_bypass_lp, 1'b1);
      wr(ADDR_CTRL, 8'h34);
      rd(ADDR_CTRL, 8'h24);
      do_stop();
      mode_is(MODE_LSTOP, REG_STANDBY);
      u_core.interrupt();
      mode_is(MODE_LOW_POWER_RUN, REG_STANDBY);
      wr(ADDR_CTRL, 8'h2C);
      do_stop();
      u_core.interrupt();
      mode_is(MODE_RUN, REG_ON);
      rd(ADDR_CTRL, 8'h28);
      rd(ADDR_STATUS, 8'h00);
      wr(ADDR_CTRL, 8'h24);
      step(2);
      do_stop();
      rst_in <= 1'b1;
      step(2);
      rst_in <= 1'b0;
      mode_is(MODE_RUN, REG_ON);
   endtask
   task t_wait;
      u_core.exec_wait();
      step(1);
      mode_is(MODE_WAIT, REG_ON);
      chk1(power_out.periph_clk_on, 1'b1);
      u_core.interrupt();
      mode_is(MODE_RUN, REG_ON);
      wr(ADDR_CTRL, 8'h24);
      step(2);
      u_core.exec_wait();
      step(1);
      mode_is(MODE_LOW_POWER_WAIT, REG_STANDBY);
      chk1(power_out.cpu_clk_on, 1'b0);
      chk1(power_out.periph_low_speed, 1'b1);
      u_core.interrupt();
      mode_is(MODE_LOW_POWER_RUN, REG_STANDBY);
      wr(ADDR_CTRL, 8'h00);
      step(2);
      mode_is(MODE_RUN, REG_ON);
   endtask

   always @(posedge clk_in)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         err_count++;
         wrap_up();
      end
   end

   initial
   begin
      step(2);
      rst_in <= 1'b0;
      t_reset();
      t_debug();
      t_deep();
      t_low_power_run();
      t_wait();
      wrap_up();
   end
endmodule
`default_nettype wire
